// ==== verilog/lcs_pkg.sv ====
`default_nettype none
package lcs_pkg;

	localparam int          LCS_NCELL      = 10;
	localparam int          LCS_REGEN_LO   = 4;
	localparam int          LCS_REGEN_HI   = 9;
	localparam int          LCS_AW         = 8;
	localparam int          LCS_DW         = 32;

	localparam logic [7:0]  LCS_CFG_BASE   = 8'h00;
	localparam logic [7:0]  LCS_CFG_STRIDE = 8'h04;
	localparam logic [7:0]  LCS_STAT_OFF   = 8'h28;

	localparam int          LCS_F_MASK     = 0;
	localparam int          LCS_F_LUTCARRY = 16;
	localparam int          LCS_F_CHEND    = 17;
	localparam int          LCS_F_CHSTART  = 18;
	localparam int          LCS_F_PRESET   = 19;
	localparam int          LCS_F_ACLRSEL  = 20;
	localparam int          LCS_F_CLKSEL   = 21;
	localparam int          LCS_F_REGCHAIN = 22;
	localparam int          LCS_F_LUTCHAIN = 23;
	localparam int          LCS_F_COUNTER  = 24;
	localparam int          LCS_F_MODE     = 25;

	localparam logic [31:0] LCS_CFG_RST    = 32'h0200_0000;
	localparam logic [31:0] LCS_CFG_WMASK  = 32'h07ff_ffff;
	localparam logic [31:0] LCS_UNMAPPED   = 32'h0000_0000;

	typedef enum logic [1:0] {
		LCS_MODE_NORMAL = 2'b01,
		LCS_MODE_ARITH  = 2'b10
	} lcs_mode_t;

	typedef struct packed {
		logic [4:0]  rsvd;
		lcs_mode_t   mode;
		logic        counter;
		logic        lut_chain;
		logic        reg_chain;
		logic        clk_sel;
		logic        aclr_sel;
		logic        preset;
		logic        chain_start;
		logic        chain_end;
		logic        lut_carry;
		logic [15:0] mask;
	} lcs_cfg_t;

	typedef struct packed {
		logic [1:0] clk_ena;
		logic [1:0] aclr;
		logic       aload;
		logic       sclr;
		logic       sload;
		logic       addnsub;
	} lcs_ctrl_t;

	typedef struct packed {
		logic operand_a;
		logic operand_b;
		logic fourth_data_input;
		logic extra_data_input;
	} lcs_data_t;

endpackage
`default_nettype wire

// ==== verilog/lcs_logic_cluster.sv ====
// Function
// - Each cell works in exactly one mode: normal or dynamic arithmetic.
// - Cell inputs: four data, zero/one carry, cluster carry-in, register chain.
// - Register clock, enables, clears, loads come from shared cluster controls.
// - Add/subtract select affects a cell only in arithmetic mode.
// - Normal mode: four-input lookup; carry or fourth input selectable.
// - Normal mode lookup output may feed the next cell directly.
// - Asynchronous load value comes from the fourth data input.
// - Normal cell uses cluster carry-in only when ending an adder chain.
// - Arithmetic mode forms two sums and two carry-outs for carry 0 and 1.
// - Cluster carry-in picks a chain; its level picks the sum.
// - Each path carry-in selects its own carry-out, sent to next cell.
// - Arithmetic cell drives registered and unregistered sum together.
// - Counter enable and up/down come from local data; clock enable offered.
// - Synchronous clear and load act at once on every cluster register whose clock enable (and counter enable, for counters) is high.
// - Add/subtract select decides add or subtract per arithmetic cell.
// - Add/subtract select feeds the carry only at a chain's first cell.
// - A carry chain may start at any cell of the cluster.
// - Carry selection is regenerated at the fifth and tenth cells.
// - Chains longer than ten cells continue into the next cluster.
// - Preset is an asynchronous load of one; clear wins over it.
// - The cluster offers two asynchronous clears and one preset.
// - Optional device-wide active-low clear resets all cell registers, not config; an asynchronous load still shows at reg_o.
// - A cluster holds ten logic cells with chains and shared controls.
// - Subtraction inverts operand_b and forces the first carry to one.
`timescale 1ns/1ps
`default_nettype none
module lcs_logic_cluster
	import lcs_pkg::*;
#(
	parameter bit DEV_CLEAR_EN = 1'b1
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       resetn_i,
	input  wire logic                       device_wide_clear_n_i,
	input  wire logic [LCS_AW-1:0]          addr_i,
	input  wire logic [LCS_DW-1:0]          wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [LCS_DW-1:0]          rdata_o,
	input  wire lcs_ctrl_t                  ctrl_i,
	input  wire lcs_data_t [LCS_NCELL-1:0]  data_i,
	input  wire logic                       carry_zero_path_in_i,
	input  wire logic                       carry_one_path_in_i,
	input  wire logic                       carry_cluster_in_i,
	input  wire logic                       reg_chain_in_i,
	output logic      [LCS_NCELL-1:0]       comb_o,
	output logic      [LCS_NCELL-1:0]       reg_o,
	output logic                            carry_zero_path_out_o,
	output logic                            carry_one_path_out_o,
	output logic                            carry_cluster_out_o,
	output logic                            lut_chain_out_o,
	output logic                            reg_chain_out_o
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic maj(input logic a, input logic b, input logic c);
		maj = (a & b) | (a & c) | (b & c);
	endfunction

	// Clear wins over load, so a preset during a clear reads low.
	function automatic logic async_view(input logic clr, input logic ld,
	                                     input logic ld_val, input logic q);
		async_view = clr ? 1'b0 : (ld ? ld_val : q);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// The device-wide clear only joins the reset when built in.
	wire logic rst_n = resetn_i & (device_wide_clear_n_i | ~DEV_CLEAR_EN);

	lcs_cfg_t [LCS_NCELL-1:0] cfg_q;
	logic     [LCS_NCELL-1:0] q_q;
	logic     [LCS_NCELL:0]   c0_chain;
	logic     [LCS_NCELL:0]   c1_chain;
	logic     [LCS_NCELL-1:0] grp_sel;
	logic                     regen_sel;
	logic     [LCS_NCELL-1:0] sel_carry;
	logic     [LCS_NCELL-1:0] lut_out;
	logic     [LCS_NCELL-1:0] d_val;
	logic     [LCS_NCELL-1:0] cap_en;
	logic     [LCS_NCELL-1:0] ld_val;
	logic     [LCS_NCELL-1:0] aclr_c;
	logic     [LCS_DW-1:0]    rdata_d;

	assign c0_chain[0] = carry_zero_path_in_i;
	assign c1_chain[0] = carry_one_path_in_i;

	////////////////////////////////////////////////////////////////////////
	// Ten cells; selection is regenerated after cell 4 so only two
	// selection points sit on the cluster's critical carry path.
	for (genvar i = 0; i < LCS_NCELL; i++) begin : g_cell
		lcs_data_t dat;
		logic      is_arith;
		logic      cin0;
		logic      cin1;
		logic      c0_in;
		logic      c1_in;
		logic      start_c;
		logic      b_eff;
		logic      n_carry;
		logic      x4;
		logic      x3;
		logic      sum;
		logic      chain_in;
		logic      q_view;

		assign dat      = data_i[i];
		assign is_arith = (cfg_q[i].mode == LCS_MODE_ARITH);

		// Counter start carry: up adds one, down adds all ones.
		assign start_c  = cfg_q[i].counter ? ~dat.operand_b
		                                   : ctrl_i.addnsub;
		// The upper half restarts both chains, so its cells need not wait
		// for the lower half; the regenerated selection picks the result.
		if (i == LCS_REGEN_LO + 1) begin : g_restart
			assign c0_in = 1'b0;
			assign c1_in = 1'b1;
		end else begin : g_follow
			assign c0_in = c0_chain[i];
			assign c1_in = c1_chain[i];
		end
		assign cin0     = cfg_q[i].chain_start ? start_c
		                                       : c0_in;
		assign cin1     = cfg_q[i].chain_start ? start_c : c1_in;

		// Subtraction inverts operand_b only in arithmetic mode.
		assign b_eff    = dat.operand_b ^ (ctrl_i.addnsub & is_arith
		                  & ~cfg_q[i].counter);

		if (i <= LCS_REGEN_LO) begin : g_lo
			assign grp_sel[i] = carry_cluster_in_i;
		end else begin : g_hi
			assign grp_sel[i] = regen_sel;
		end

		logic op_a;
		assign op_a = cfg_q[i].counter ? q_q[i] : dat.operand_a;

		assign c0_chain[i+1] = maj(op_a, b_eff, cin0);
		assign c1_chain[i+1] = maj(op_a, b_eff, cin1);
		assign sel_carry[i]  = grp_sel[i] ? cin1 : cin0;
		assign sum = grp_sel[i] ? (op_a ^ b_eff ^ cin1)
		                        : (op_a ^ b_eff ^ cin0);

		// Normal mode sees the cluster carry only at the end of a chain.
		assign n_carry  = cfg_q[i].chain_end ? sel_carry[i] : 1'b0;
		if (i == 0) begin : g_first
			assign chain_in = 1'b0;
		end else begin : g_next
			assign chain_in = lut_out[i-1];
		end
		assign x4 = cfg_q[i].lut_chain ? chain_in : dat.extra_data_input;
		assign x3 = cfg_q[i].lut_carry ? n_carry
		                               : dat.fourth_data_input;
		assign lut_out[i] = cfg_q[i].mask[{x4, x3, dat.operand_b,
		                                   dat.operand_a}];

		assign comb_o[i] = is_arith ? sum : lut_out[i];

		// Register path: chain input or the cell's own function.
		if (i == 0) begin : g_rc0
			assign d_val[i] = cfg_q[i].reg_chain ? reg_chain_in_i : comb_o[i];
		end else begin : g_rcn
			assign d_val[i] = cfg_q[i].reg_chain ? q_q[i-1] : comb_o[i];
		end
		assign ld_val[i] = cfg_q[i].preset | dat.fourth_data_input;
		assign aclr_c[i] = ctrl_i.aclr[cfg_q[i].aclr_sel];
		assign cap_en[i] = ctrl_i.clk_ena[cfg_q[i].clk_sel]
		                   & (~(is_arith & cfg_q[i].counter)
		                      | dat.extra_data_input);

		// Asynchronous clear and load act on the output at once and are
		// captured at the next edge; the flop itself only resets to zero.
		assign q_view    = async_view(aclr_c[i], ctrl_i.aload, ld_val[i],
		                              q_q[i]);
		assign reg_o[i]  = q_view;

		always_ff @(posedge clk_sys_i or negedge rst_n) begin
			if (!rst_n) begin
				q_q[i] <= 1'b0;
			end else if (aclr_c[i] | ctrl_i.aload) begin
				q_q[i] <= q_view;
			end else if (cap_en[i]) begin
				if (ctrl_i.sclr) begin
					q_q[i] <= 1'b0;
				end else if (ctrl_i.sload) begin
					q_q[i] <= dat.fourth_data_input;
				end else begin
					q_q[i] <= d_val[i];
				end
			end
		end

		//////////////////////////////////////////////////////////////////
		aclr_wins_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			aclr_c[i] |-> !reg_o[i])
			else $error("async clear did not force the register low");
		aload_val_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			ctrl_i.aload && !aclr_c[i] |-> reg_o[i] == ld_val[i]
			##1 q_q[i] == $past(ld_val[i]))
			else $error("async load value not taken from fourth input");
		hold_no_ena_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			!cap_en[i] && !aclr_c[i] && !ctrl_i.aload |=> $stable(q_q[i]))
			else $error("register changed without clock enable");
		sync_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			cap_en[i] && ctrl_i.sclr && !aclr_c[i] && !ctrl_i.aload
			|=> !q_q[i])
			else $error("sync clear missed");
		sum_select_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			is_arith |-> comb_o[i] == (op_a ^ b_eff ^ sel_carry[i]))
			else $error("sum not chosen by selected chain");
		normal_no_sub_a: assert property (@(posedge clk_sys_i)
			disable iff (!rst_n)
			!is_arith |-> comb_o[i] == lut_out[i] && b_eff == dat.operand_b)
			else $error("add or subtract leaked into normal mode");
		carry_path_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			c1_chain[i+1] == maj(op_a, b_eff, cin1)
			&& c0_chain[i+1] == maj(op_a, b_eff, cin0))
			else $error("carry-out not selected by its own path");
		sub_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			is_arith && cfg_q[i].chain_start && !cfg_q[i].counter
			&& ctrl_i.addnsub |-> cin0 && cin1 && b_eff == !dat.operand_b)
			else $error("subtract chain start not forced to one");
		one_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
			$onehot(cfg_q[i].mode))
			else $error("cell mode not one-hot");
	end

	////////////////////////////////////////////////////////////////////////
	// Carries leave through both paths and the regenerated selection.
	assign carry_zero_path_out_o = c0_chain[LCS_NCELL];
	assign carry_one_path_out_o  = c1_chain[LCS_NCELL];
	assign regen_sel             = grp_sel[LCS_REGEN_LO]
	                               ? c1_chain[LCS_REGEN_LO+1]
	                               : c0_chain[LCS_REGEN_LO+1];
	assign carry_cluster_out_o   = grp_sel[LCS_REGEN_HI]
	                               ? c1_chain[LCS_NCELL]
	                               : c0_chain[LCS_NCELL];
	assign lut_chain_out_o       = lut_out[LCS_NCELL-1];
	assign reg_chain_out_o       = q_q[LCS_NCELL-1];

	regen_hi_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
		grp_sel[LCS_REGEN_LO+1] == maj(g_cell[LCS_REGEN_LO].op_a,
			g_cell[LCS_REGEN_LO].b_eff, sel_carry[LCS_REGEN_LO])
		&& carry_cluster_out_o == maj(g_cell[LCS_REGEN_HI].op_a,
			g_cell[LCS_REGEN_HI].b_eff, sel_carry[LCS_REGEN_HI]))
		else $error("carry selection not regenerated");

	////////////////////////////////////////////////////////////////////////
	// Register port: one config word per cell, then a status word.
	logic [LCS_NCELL-1:0] hit_cfg;
	wire  logic           hit_stat = (addr_i == LCS_STAT_OFF);

	for (genvar r = 0; r < LCS_NCELL; r++) begin : g_reg
		assign hit_cfg[r] = (addr_i == LCS_CFG_BASE + 8'(r) * LCS_CFG_STRIDE);

		// An illegal mode code falls back to normal mode.
		wire lcs_cfg_t wcfg = lcs_cfg_t'(wdata_i & LCS_CFG_WMASK);
		wire lcs_cfg_t wfix = (wcfg.mode == LCS_MODE_ARITH)
		                      ? wcfg : lcs_cfg_t'({wcfg[31:27], LCS_MODE_NORMAL,
		                                           wcfg[24:0]});

		always_ff @(posedge clk_sys_i or negedge resetn_i) begin
			if (!resetn_i) begin
				cfg_q[r] <= lcs_cfg_t'(LCS_CFG_RST);
			end else if (wr_i && hit_cfg[r]) begin
				cfg_q[r] <= wfix;
			end
		end
	end

	always_comb begin
		rdata_d = LCS_UNMAPPED;
		for (int k = 0; k < LCS_NCELL; k++) begin
			if (hit_cfg[k]) begin
				rdata_d = 32'(cfg_q[k]);
			end
		end
		if (hit_stat) begin
			rdata_d = {9'h000, carry_cluster_out_o, carry_one_path_out_o,
			           carry_zero_path_out_o, reg_o, comb_o};
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= LCS_UNMAPPED;
		end else if (rd_i) begin
			rdata_o <= rdata_d;
		end else begin
			rdata_o <= LCS_UNMAPPED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	cov_sub_c:   cover property (@(posedge clk_sys_i) disable iff (!rst_n)
		ctrl_i.addnsub && cfg_q[0].mode == LCS_MODE_ARITH);
	cov_regen_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
		sel_carry[LCS_REGEN_LO] != carry_cluster_in_i);
	cov_pre_c:   cover property (@(posedge clk_sys_i) disable iff (!rst_n)
		ctrl_i.aload && ctrl_i.aclr[0] && ctrl_i.aclr[1]);
	cov_chain_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
		cfg_q[3].lut_chain && cfg_q[3].mode == LCS_MODE_NORMAL);

endmodule
`default_nettype wire

// ==== verif/lcs_nbr_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stands in for the previous cell, the previous cluster and the cluster
// control logic. Each drives from its own flop, so these inputs move only
// after a clock edge, as real neighbours would.
module lcs_nbr_model
	import lcs_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	input  wire lcs_ctrl_t  ctrl_i,
	input  wire logic [3:0] chain_i,
	output var  lcs_ctrl_t  ctrl_o,
	output logic      [3:0] chain_o
);
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_o  <= '0;
			chain_o <= '0;
		end else begin
			ctrl_o  <= ctrl_i;
			chain_o <= chain_i;
		end
	end
endmodule
`default_nettype wire

// ==== verif/test_lcs_logic_cluster.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_lcs_logic_cluster;
	import lcs_pkg::*;
	typedef struct {
		logic [9:0] a;
		logic [9:0] b;
		logic [4:0] f;
	} lcs_row_t;
	logic            clk_sys_i = 1'b0;
	logic            resetn_i = 1'b0;
	logic            device_wide_clear_n = 1'b1;
	logic [7:0]      addr = 8'h00;
	logic [31:0]     wdata = 32'h0;
	logic            wr = 1'b0;
	logic            rd = 1'b0;
	logic [31:0]     rdata;
	lcs_ctrl_t       ctrl_d = '0;
	lcs_ctrl_t       ctrl;
	lcs_data_t [9:0] data = '0;
	logic [3:0]      chain_d = 4'h0;
	logic [3:0]      chain;
	logic [9:0]      comb;
	logic [9:0]      regq;
	logic            cz, co, cc_o, lut_o, rc_o;
	int              n_errors = 0;
	int              n_tests = 0;
	int              cyc = 0;
	// Flags are {sub, chain start, zero-path in, one-path in, cluster in}.
	lcs_row_t rows [7] = '{'{10'h3ff, 10'h001, 5'h08},
		'{10'h155, 10'h2aa, 5'h08}, '{10'h000, 10'h001, 5'h18},
		'{10'h200, 10'h100, 5'h18}, '{10'h01f, 10'h001, 5'h03},
		'{10'h1ff, 10'h200, 5'h05}, '{10'h1ff, 10'h200, 5'h04}};

	always #20 clk_sys_i = ~clk_sys_i;

	lcs_logic_cluster #(.DEV_CLEAR_EN(1'b1)) u_dut (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.device_wide_clear_n_i(device_wide_clear_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .ctrl_i(ctrl), .data_i(data),
		.carry_zero_path_in_i(chain[0]), .carry_one_path_in_i(chain[1]),
		.carry_cluster_in_i(chain[2]), .reg_chain_in_i(chain[3]),
		.comb_o(comb), .reg_o(regq), .carry_zero_path_out_o(cz),
		.carry_one_path_out_o(co), .carry_cluster_out_o(cc_o),
		.lut_chain_out_o(lut_o), .reg_chain_out_o(rc_o));

	lcs_nbr_model u_nbr (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ctrl_i(ctrl_d),
		.chain_i(chain_d), .ctrl_o(ctrl), .chain_o(chain));

	////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(string what, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask

	task wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask

	task rd_chk(string what, logic [7:0] a, logic [31:0] e);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		chk(what, e, rdata);
	endtask

	task cfg_all(logic [31:0] v);
		for (int i = 0; i < 10; i++)
			wr_reg(8'(4 * i), v);
	endtask

	// Controls pass the neighbour flop, so data follow one edge later.
	task go(lcs_ctrl_t c, logic [3:0] ch, lcs_data_t [9:0] d);
		@(posedge clk_sys_i);
		ctrl_d <= c;
		chain_d <= ch;
		@(posedge clk_sys_i);
		data <= d;
		@(posedge clk_sys_i);
		#1;
	endtask

	task step(string what, lcs_ctrl_t c, logic a, logic f, logic [9:0] e);
		lcs_data_t [9:0] d;
		for (int i = 0; i < 10; i++)
			d[i] = {a, 1'b0, f, 1'b0};
		go(c, 4'h0, d);
		chk(what, {22'h0, e}, {22'h0, regq});
	endtask

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		lcs_data_t [9:0] d;
		logic [10:0]     e;
		logic            cin;
		logic [5:0]      h;
		repeat (4) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rd_chk("cfg after reset", LCS_CFG_BASE, LCS_CFG_RST);
		wr_reg(8'h2c, 32'hffff_ffff);
		rd_chk("unmapped read", 8'h2c, LCS_UNMAPPED);
		wr_reg(8'h04, 32'hffff_ffff);
		rd_chk("cfg bad mode", 8'h04, 32'h03ff_ffff);
		$display("test registers done");

		cfg_all(32'h0200_6996);
		for (int k = 0; k < 16; k++) begin
			for (int i = 0; i < 10; i++)
				d[i] = {k[0], k[1], k[2], k[3]};
			go(lcs_ctrl_t'({7'h0, k[0]}), 4'h0, d);
			chk("lookup", {22'h0, {10{^k[3:0]}}}, {22'h0, comb});
			chk("lut out", {31'h0, ^k[3:0]}, {31'h0, lut_o});
		end
		$display("test normal mode done");

		cfg_all(32'h0400_0000);
		foreach (rows[r]) begin
			wr_reg(8'h00, 32'h0400_0000 | {13'h0, rows[r].f[3], 18'h0});
			for (int i = 0; i < 10; i++)
				d[i] = {rows[r].a[i], rows[r].b[i], 2'b00};
			go(lcs_ctrl_t'({7'h20, rows[r].f[4]}), {1'b0, rows[r].f[0],
				rows[r].f[1], rows[r].f[2]}, d);
			cin = rows[r].f[3] ? rows[r].f[4]
				: (rows[r].f[0] ? rows[r].f[1] : rows[r].f[2]);
			e = {1'b0, rows[r].a} + {1'b0, rows[r].f[4] ? ~rows[r].b
				: rows[r].b} + {10'h0, cin};
			chk("sum", {22'h0, e[9:0]}, {22'h0, comb});
			chk("reg sum", {22'h0, e[9:0]}, {22'h0, regq});
			chk("carry out", {31'h0, e[10]}, {31'h0, cc_o});
			h = {1'b0, rows[r].a[9:5]} + {1'b0, rows[r].f[4]
				? ~rows[r].b[9:5] : rows[r].b[9:5]};
			chk("zero out", {31'h0, h[5]}, {31'h0, cz});
			chk("one out", {31'h0, h[5] | (&h[4:0])}, {31'h0, co});
		end
		$display("test arithmetic done");

		cfg_all(32'h0200_aaaa);
		step("async clear", 8'h30, 1'b1, 1'b0, 10'h000);
		step("hold disabled", 8'h00, 1'b1, 1'b0, 10'h000);
		step("capture", 8'h40, 1'b1, 1'b0, 10'h3ff);
		step("hold", 8'h00, 1'b0, 1'b0, 10'h3ff);
		step("sync clear", 8'h44, 1'b1, 1'b0, 10'h000);
		step("sync load", 8'h42, 1'b0, 1'b1, 10'h3ff);
		step("clear wins", 8'h18, 1'b1, 1'b1, 10'h000);
		step("async load", 8'h08, 1'b0, 1'b1, 10'h3ff);
		step("async load 0", 8'h08, 1'b1, 1'b0, 10'h000);
		cfg_all(32'h020a_aaaa);
		step("preset", 8'h08, 1'b0, 1'b0, 10'h3ff);
		cfg_all(32'h0200_aaaa);
		step("recapture", 8'h40, 1'b1, 1'b0, 10'h3ff);
		chk("reg chain out", 32'h1, {31'h0, rc_o});
		@(posedge clk_sys_i);
		device_wide_clear_n <= 1'b0;
		step("device clear", 8'h40, 1'b1, 1'b0, 10'h000);
		device_wide_clear_n <= 1'b1;
		$display("test cell register done");

		wr_reg(8'h00, 32'h0203_f0f0);
		wr_reg(8'h04, 32'h0280_ff00);
		wr_reg(8'h08, 32'h0201_f0f0);
		go('0, 4'h6, '0);
		chk("carry lookup", 32'h3, {29'h0, comb[2:0]});
		go('0, 4'h2, '0);
		chk("carry lookup 0", 32'h0, {29'h0, comb[2:0]});
		$display("test chains done");
		summarize();
	end
endmodule
`default_nettype wire
